// ---- hdl/tmz_regs.vh ----
`ifndef TMZ_REGS_VH
`define TMZ_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// Register indices on the Avalon word address
`define TMZ_ADDR_W          3
`define TMZ_IDX_TIMER       3'h1
`define TMZ_IDX_OPTION      3'h2
`define TMZ_IDX_DIRECTION   3'h3
`define TMZ_IDX_WDCLEAR     3'h4

////////////////////////////////////////////////////////////////////////////////
// Option register field positions
`define TMZ_OPT_WAKE_DIS    7
`define TMZ_OPT_PULLUP_DIS  6
`define TMZ_OPT_CLK_SRC     5
`define TMZ_OPT_EDGE        4
`define TMZ_OPT_ASSIGN      3
`define TMZ_OPT_RATIO_HI    2
`define TMZ_OPT_RATIO_LO    0

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define TMZ_RST_TIMER       8'h00
`define TMZ_RST_OPTION      8'hFF
`define TMZ_RST_DIRECTION   6'h3F
`define TMZ_RST_DIVIDER     8'h00

////////////////////////////////////////////////////////////////////////////////
// Quarter phases of the instruction cycle, one oscillator period each
`define TMZ_PH_Q1           2'h0
`define TMZ_PH_Q2           2'h1
`define TMZ_PH_Q3           2'h2
`define TMZ_PH_Q4           2'h3

////////////////////////////////////////////////////////////////////////////////
// Timing counts
`define TMZ_INHIBIT_CYCLES  2'h2
`define TMZ_TOSC_NS         4

`endif

// ---- hdl/tmz_divider.v ----
`timescale 1ns/10ps
`include "tmz_regs.vh"

// Shared 8-bit divider: prescaler for the timer or postscaler for the watchdog
module tmz_divider #(
	parameter WIDTH = 8	// Divider length
) (
	// Clock and control
	input  wire             mclk,
	input  wire             nrst,
	input  wire             ce,
	// Count control
	input  wire             clear,		// Zero the count
	input  wire             step,		// Advance by one
	input  wire [2:0]       ratio,		// Selected tap
	// Divided output
	output wire             tap			// Selected count bit
);

	reg  [WIDTH-1:0]        cnt_reg;	// Hidden divider count
	reg  [WIDTH-1:0]        cnt_next;	// Next count

	////////////////////////////////////////////////////////////////////////////
	// Clear has priority over a step; nothing can load a value
	always @* begin
		cnt_next = cnt_reg;
		if (clear) begin
			cnt_next = `TMZ_RST_DIVIDER;
		end else if (step) begin
			cnt_next = cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	// Count register, zero at reset
	always @(posedge mclk) begin
		if (!nrst) begin
			cnt_reg <= `TMZ_RST_DIVIDER;
		end else if (ce) begin
			cnt_reg <= cnt_next;
		end
	end

	// Tap n toggles every 2^n steps, so it divides by 2^(n+1)
	assign tap = cnt_reg[ratio];

endmodule // tmz_divider

// ---- hdl/tmz_phase_sampler.v ----
`timescale 1ns/10ps
`include "tmz_regs.vh"

// Samples a level at Q2 and Q4 and flags a low-to-high change
module tmz_phase_sampler (
	// Clock and control
	input  wire             mclk,
	input  wire             nrst,
	input  wire             ce,
	// Phase and level
	input  wire [1:0]       phase,		// Current quarter phase
	input  wire             level,		// Level to be sampled
	// Result
	output reg              rise		// One-cycle pulse on a rising sample
);

	reg                     samp_reg;	// Last sampled level
	wire                    samp_now;	// This is a sampling phase

	// Only Q2 and Q4 are sampling points
	assign samp_now = (phase == `TMZ_PH_Q2) || (phase == `TMZ_PH_Q4);

	////////////////////////////////////////////////////////////////////////////
	// Keep the sample and mark a 0 to 1 step between two samples
	always @(posedge mclk) begin
		if (!nrst) begin
			// Start high so a level already up at reset is not a false edge
			samp_reg <= 1'b1;
			rise     <= 1'b0;
		end else if (ce) begin
			rise <= 1'b0;
			if (samp_now) begin
				samp_reg <= level;
				rise     <= level & ~samp_reg;
			end
		end
	end

endmodule // tmz_phase_sampler

// ---- hdl/tmz_timer0.v ----
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/10ps
`include "tmz_regs.vh"

// Contract
// - Clock select clear: count instruction cycles
// - Counter write blocks increments two cycles
// - Clock select set: count external pin edges
// - Edge bit: clear rising, set falling
// - Divider serves timer or watchdog, never both
// - Timer divider ratios 1:2 through 1:256
// - Divider count unreadable and not loadable
// - Counter write clears divider when timer-assigned
// - Watchdog clear zeroes divider when watchdog-assigned
// - Reset forces divider to zero
// - Divider output sampled at Q2, Q4
// - Divider runs ahead of phase synchronisation
// - Pin change to increment three to seven
// - Shared divider is eight bits wide
// - Counter: 8-bit read/write register at 01h
// - External clock select overrides pin direction
module tmz_timer0 #(
	parameter CNT_PIN = 3'h2	// Port bit shared with the counter clock input
) (
	// Clock, reset and enable
	input  wire             mclk,
	input  wire             nrst,
	input  wire             ce,
	// Avalon-MM slave
	input  wire [2:0]       avs_address,
	input  wire             avs_read,
	input  wire             avs_write,
	input  wire [31:0]      avs_writedata,
	output reg  [31:0]      avs_readdata,
	output wire             avs_waitrequest,
	// Counter clock pin
	input  wire             counter_clock_input,
	// Watchdog side
	input  wire             wdt_tick,
	output reg              watchdog_clear_instruction,
	output reg              wdt_timeout,
	// Option and port control outputs
	output wire             pin_wake_disable,
	output wire             pullup_disable,
	output wire [5:0]       port_direction_bits,
	// Timer state
	output wire [7:0]       timer_value,
	output reg              timer_overflow
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	reg  [1:0]              phase_reg;			// Quarter phase Q1..Q4
	reg  [7:0]              timer_count_reg;	// Software-visible counter
	reg  [7:0]              timer_count_next;	// Next counter value
	reg  [7:0]              option_control_reg;	// Write-only options
	reg  [5:0]              port_direction_reg;	// Write-only direction bits
	reg  [1:0]              inhibit_reg;		// Suppressed cycles left
	reg  [1:0]              inhibit_next;		// Next inhibit count
	reg                     pin_meta_reg;		// Pin synchroniser stage one
	reg                     pin_sync_reg;		// Pin synchroniser stage two
	reg                     sel_prev_reg;		// Selected pin level, last cycle
	reg                     rd_done_reg;		// Read answer ready
	reg                     wd_tap_prev_reg;	// Watchdog tap, last cycle
	wire                    q4;					// Last quarter of a cycle
	wire                    wr_take;			// Write accepted this cycle
	wire                    wr_timer;			// Counter register write
	wire                    wr_option;			// Option register write
	wire                    wr_dir;				// Direction register write
	wire                    wr_wdclr;			// Watchdog clear command
	wire                    clk_src;			// External clock selected
	wire                    edge_fall;			// Falling edge selected
	wire                    to_watchdog;		// Divider serves watchdog
	wire [2:0]              ratio;				// Divider tap select
	wire                    pin_sel;			// Pin level, edge-adjusted
	wire                    pin_edge;			// Counting edge on the pin
	wire                    inst_level;			// Instruction clock level
	wire                    raw_level;			// Undivided source level
	reg                     div_step;			// Divider advance
	wire                    div_clear;			// Divider clear
	wire                    div_tap;			// Divider selected output
	wire                    samp_level;			// Level fed to the sampler
	wire                    samp_rise;			// Synchronised source edge
	wire                    inc_ok;				// Increment allowed

	////////////////////////////////////////////////////////////////////////////
	// Option field decode
	assign clk_src     = option_control_reg[`TMZ_OPT_CLK_SRC];
	assign edge_fall   = option_control_reg[`TMZ_OPT_EDGE];
	assign to_watchdog = option_control_reg[`TMZ_OPT_ASSIGN];
	assign ratio       = option_control_reg[`TMZ_OPT_RATIO_HI:`TMZ_OPT_RATIO_LO];

	assign pin_wake_disable = option_control_reg[`TMZ_OPT_WAKE_DIS];
	assign pullup_disable   = option_control_reg[`TMZ_OPT_PULLUP_DIS];

	////////////////////////////////////////////////////////////////////////////
	// Quarter phase generator, one oscillator period per phase
	always @(posedge mclk) begin
		if (!nrst) begin
			phase_reg <= `TMZ_PH_Q1;
		end else if (ce) begin
			phase_reg <= phase_reg + 2'h1;
		end
	end

	assign q4 = (phase_reg == `TMZ_PH_Q4);

	////////////////////////////////////////////////////////////////////////////
	// Bus decode; writes complete at the end of an instruction cycle
	assign wr_take   = ce & avs_write & q4;
	assign wr_timer  = wr_take & (avs_address == `TMZ_IDX_TIMER);
	assign wr_option = wr_take & (avs_address == `TMZ_IDX_OPTION);
	assign wr_dir    = wr_take & (avs_address == `TMZ_IDX_DIRECTION);
	assign wr_wdclr  = wr_take & (avs_address == `TMZ_IDX_WDCLEAR);

	// Stall writes until Q4, reads until the answer is registered
	assign avs_waitrequest = (avs_write & ~wr_take) | (avs_read & ~rd_done_reg);

	////////////////////////////////////////////////////////////////////////////
	// Read path; the divider count has no address and reads nowhere
	always @(posedge mclk) begin
		if (!nrst) begin
			rd_done_reg  <= 1'b0;
			avs_readdata <= 32'h00000000;
		end else if (ce) begin
			rd_done_reg <= avs_read & ~rd_done_reg;
			if (avs_read & ~rd_done_reg) begin
				// Only the counter reads back; others read as zero
				if (avs_address == `TMZ_IDX_TIMER) begin
					avs_readdata <= {24'h000000, timer_count_reg};
				end else begin
					avs_readdata <= 32'h00000000;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Option and direction registers
	always @(posedge mclk) begin
		if (!nrst) begin
			option_control_reg <= `TMZ_RST_OPTION;
			port_direction_reg <= `TMZ_RST_DIRECTION;
		end else if (ce) begin
			if (wr_option) begin
				option_control_reg <= avs_writedata[7:0];
			end
			if (wr_dir) begin
				port_direction_reg <= avs_writedata[5:0];
			end
		end
	end

	// Counter clock function forces its pin to input
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi = gi + 1) begin : g_dir
			if (gi == CNT_PIN) begin : g_force
				assign port_direction_bits[gi] = port_direction_reg[gi] | clk_src;
			end else begin : g_plain
				assign port_direction_bits[gi] = port_direction_reg[gi];
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Pin synchroniser and counting-edge detector
	always @(posedge mclk) begin
		if (!nrst) begin
			pin_meta_reg <= 1'b0;
			pin_sync_reg <= 1'b0;
			// Idle pin with falling edge selected reads high: no false edge
			sel_prev_reg <= 1'b1;
		end else if (ce) begin
			pin_meta_reg <= counter_clock_input;
			pin_sync_reg <= pin_meta_reg;
			sel_prev_reg <= pin_sel;
		end
	end

	// Inverting the pin turns a falling edge into a rising one
	assign pin_sel  = pin_sync_reg ^ edge_fall;
	assign pin_edge = pin_sel & ~sel_prev_reg;

	// Instruction clock is high in Q3 and Q4
	assign inst_level = phase_reg[1];
	assign raw_level  = clk_src ? pin_sel : inst_level;

	////////////////////////////////////////////////////////////////////////////
	// Divider source and clears
	always @* begin
		div_step = 1'b0;
		if (to_watchdog) begin
			div_step = wdt_tick;
		end else if (clk_src) begin
			div_step = pin_edge;
		end else begin
			div_step = q4;
		end
	end

	assign div_clear = (wr_timer & ~to_watchdog) | (wr_wdclr & to_watchdog);

	tmz_divider #(
		.WIDTH (8)
	) u_divider (
		.mclk  (mclk),
		.nrst  (nrst),
		.ce    (ce),
		.clear (div_clear),
		.step  (div_step),
		.ratio (ratio),
		.tap   (div_tap)
	);

	// Timer sees the divider only while it owns it
	assign samp_level = to_watchdog ? raw_level : div_tap;

	tmz_phase_sampler u_sampler (
		.mclk  (mclk),
		.nrst  (nrst),
		.ce    (ce),
		.phase (phase_reg),
		.level (samp_level),
		.rise  (samp_rise)
	);

	////////////////////////////////////////////////////////////////////////////
	// Inhibit window after a counter write
	always @* begin
		inhibit_next = inhibit_reg;
		if (wr_timer) begin
			inhibit_next = `TMZ_INHIBIT_CYCLES;
		end else if (q4 && (inhibit_reg != 2'h0)) begin
			inhibit_next = inhibit_reg - 2'h1;
		end
	end

	assign inc_ok = samp_rise & (inhibit_reg == 2'h0);

	////////////////////////////////////////////////////////////////////////////
	// Counter next value; a write wins over an increment
	always @* begin
		timer_count_next = timer_count_reg;
		if (wr_timer) begin
			timer_count_next = avs_writedata[7:0];
		end else if (inc_ok) begin
			timer_count_next = timer_count_reg + 8'h01;
		end
	end

	// Counter, inhibit and overflow flag
	always @(posedge mclk) begin
		if (!nrst) begin
			timer_count_reg <= `TMZ_RST_TIMER;
			inhibit_reg     <= 2'h0;
			timer_overflow  <= 1'b0;
		end else if (ce) begin
			timer_count_reg <= timer_count_next;
			inhibit_reg     <= inhibit_next;
			timer_overflow  <= ~wr_timer & inc_ok & (timer_count_reg == 8'hFF);
		end
	end

	assign timer_value = timer_count_reg;

	////////////////////////////////////////////////////////////////////////////
	// Watchdog postscaler output and clear strobe
	always @(posedge mclk) begin
		if (!nrst) begin
			wd_tap_prev_reg            <= 1'b0;
			wdt_timeout                <= 1'b0;
			watchdog_clear_instruction <= 1'b0;
		end else if (ce) begin
			wd_tap_prev_reg            <= div_tap;
			watchdog_clear_instruction <= wr_wdclr;
			if (to_watchdog) begin
				// Falling tap ends one full postscaled period
				wdt_timeout <= wd_tap_prev_reg & ~div_tap & ~div_clear;
			end else begin
				// Undivided watchdog tick when the timer owns the divider
				wdt_timeout <= wdt_tick;
			end
		end
	end

endmodule // tmz_timer0

// ---- tb/tmz_timer0_properties.sv ----
`timescale 1ns/10ps
`include "tmz_regs.vh"

// Port-level watch on the timer block
module tmz_chk (
	// Clock and reset
	input wire        mclk,
	input wire        nrst,
	input wire        ce,
	// Register bus
	input wire [2:0]  avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_writedata,
	input wire [31:0] avs_readdata,
	input wire        avs_waitrequest,
	// Block outputs
	input wire        watchdog_clear_instruction,
	input wire [5:0]  port_direction_bits,
	input wire [7:0]  timer_value
);
	reg  [7:0] opt_q;                                  // Shadow of the option register
	reg  [7:0] wd_q;                                   // Last byte loaded into the counter
	reg  [7:0] tv_q;                                   // Counter one cycle back
	reg        wr_q;                                   // Counter load in the last cycle
	reg  [3:0] age_q;                                  // Cycles since a taken write
	wire       take   = ce && avs_write && !avs_waitrequest;
	wire       wr_tmr = take && avs_address == `TMZ_IDX_TIMER;
	wire       inc    = timer_value != tv_q && !wr_q;  // Counter stepped on its own

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	////////////////////////////////////////////////////////////////////////////////
	// History kept for the properties; age saturates so it never wraps
	always @(posedge mclk) begin
		tv_q <= timer_value;
		wr_q <= wr_tmr && nrst;
		if (wr_tmr)
			wd_q <= avs_writedata[7:0];
		if (!nrst) begin
			opt_q <= `TMZ_RST_OPTION;
			age_q <= 4'hF;
		end else begin
			if (take && avs_address == `TMZ_IDX_OPTION)
				opt_q <= avs_writedata[7:0];
			if (take)
				age_q <= 4'h0;
			else if (age_q != 4'hF)
				age_q <= age_q + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Loaded byte stands through the blocked instruction cycles
	sequence s_load_held;
		(timer_value == wd_q) [*8];
	endsequence
	// Read answer: one wait cycle, then done
	sequence s_read_answer;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence

	AST_READ_ONE_WAIT: assert property ($rose(avs_read) |-> s_read_answer)
		else $error("read answered at the wrong cycle");
	AST_WRITE_BOUND: assert property (ce && avs_write |-> ##[0:3] !avs_waitrequest)
		else $error("write not taken within an instruction cycle");
	AST_READ_DATA: assert property ($rose(avs_read) |=>
		avs_readdata[31:8] == 24'h0 &&
		(avs_address == `TMZ_IDX_TIMER || avs_readdata[7:0] == 8'h00))
		else $error("hidden register leaked on a read");
	AST_LOAD_HOLD: assert property (wr_tmr |=> s_load_held)
		else $error("counter moved right after a load");
	AST_STEP_ONE: assert property (inc |-> timer_value == tv_q + 8'h01)
		else $error("counter stepped by other than one");
	AST_STEP_GAP: assert property (inc && !opt_q[5] |=> !inc [*3])
		else $error("two steps inside one instruction cycle");
	AST_STEP_CADENCE: assert property (inc && opt_q[5:3] == 3'b001 |->
		##4 (inc || age_q < 4'h5))
		else $error("bare timer missed an instruction cycle");
	AST_WDCLR_PULSE: assert property (take && avs_address == `TMZ_IDX_WDCLEAR |=>
		watchdog_clear_instruction ##1 !watchdog_clear_instruction)
		else $error("watchdog clear pulse wrong");
	AST_PIN_OVERRIDE: assert property (opt_q[5] |-> port_direction_bits[2])
		else $error("counter pin not forced to input");
endmodule // tmz_chk

bind tmz_timer0 tmz_chk u_tmz_chk (
	.mclk(mclk), .nrst(nrst), .ce(ce), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.watchdog_clear_instruction(watchdog_clear_instruction),
	.port_direction_bits(port_direction_bits), .timer_value(timer_value)
);

// ---- tb/tmz_ext_src.sv ----
`timescale 1ns/10ps

// External clock source on the counter clock pin
module tmz_ext_src (
	// Clock and request
	input  wire       mclk,
	input  wire       start,   // Begin a burst
	input  wire [7:0] pulses,  // Full periods in one burst
	// Pin drive
	output reg        pin      // Idles low between bursts
);
	integer left = 0;  // Half periods still to send
	integer hold = 0;  // Cycles spent at the present level

	initial pin = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// Each level stands four cycles, above both pulse-width minimums
	always @(posedge mclk) begin
		if (start) begin
			left <= 2 * pulses;
			hold <= 0;
		end else if (left > 0 && hold == 3) begin
			pin  <= ~pin;
			left <= left - 1;
			hold <= 0;
		end else if (left > 0) begin
			hold <= hold + 1;
		end
	end
endmodule // tmz_ext_src

// ---- tb/tb.sv ----
`timescale 1ns/10ps
`include "tmz_regs.vh"

`define CHK(nm, e, g) begin \
	checks_done = checks_done + 1; \
	if ((g) !== (e)) begin \
		n_mismatch = n_mismatch + 1; \
		$display("wrong value %s expected %h seen %h", nm, e, g); \
	end \
end

// Self-checking bench for the timer block
module tb;
	reg         mclk          = 1'b0;   // 250 MHz clock
	reg         nrst          = 1'b0;   // Held low twenty cycles
	reg  [2:0]  avs_address   = 3'h0;
	reg         avs_read      = 1'b0;
	reg         avs_write     = 1'b0;
	reg  [31:0] avs_writedata = 32'h0;
	reg         start         = 1'b0;   // Burst request to the clock source
	wire [31:0] avs_readdata;
	wire        avs_waitrequest;
	wire        pin;                    // Counter clock pin
	wire        wdc;                    // Watchdog clear pulse
	wire [5:0]  dir;                    // Port direction bits
	wire [7:0]  tv;                     // Counter value
	wire        ovf;                    // Overflow pulse
	wire        wkd;                    // Wake disable option bit
	wire        pud;                    // Pull-up disable option bit
	integer     n_ovf         = 0;      // Overflow pulses seen
	integer     n_mismatch    = 0;
	integer     checks_done   = 0;
	integer     i;
	reg  [7:0]  a;                      // Scratch read byte
	reg  [7:0]  b;                      // Counter snapshot or option byte

	always #2 mclk = ~mclk;

	tmz_timer0 u_tmz_timer0 (
		.mclk(mclk), .nrst(nrst), .ce(1'b1),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .counter_clock_input(pin),
		.wdt_tick(1'b0), .watchdog_clear_instruction(wdc), .wdt_timeout(),
		.pin_wake_disable(wkd), .pullup_disable(pud),
		.port_direction_bits(dir), .timer_value(tv), .timer_overflow(ovf)
	);

	// Count overflow pulses
	always @(posedge mclk) begin
		if (ovf === 1'b1)
			n_ovf <= n_ovf + 1;
	end
	tmz_ext_src u_tmz_ext_src (.mclk(mclk), .start(start), .pulses(8'h08), .pin(pin));

	////////////////////////////////////////////////////////////////////////////////
	// One bus transfer, held until the edge that takes it
	task xfer(input rd, input [2:0] ad, input [7:0] wd, output [7:0] q);
		integer k;
		begin
			@(posedge mclk);
			avs_read      <= rd;
			avs_write     <= !rd;
			avs_address   <= ad;
			avs_writedata <= {24'h0, wd};
			k = 0;
			@(posedge mclk);
			while (avs_waitrequest !== 1'b0 && k < 50) begin
				k = k + 1;
				@(posedge mclk);
			end
			`CHK("bus answer", 1'b0, avs_waitrequest)
			q = avs_readdata[7:0];
			avs_read  <= 1'b0;
			avs_write <= 1'b0;
			#1;
		end
	endtask

	// Verdict and end of run
	task summarize;
		begin
			$display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
			if (n_mismatch == 0 && checks_done > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask

	// Cut a hung run short
	initial begin
		#200000;
		n_mismatch = n_mismatch + 1;
		summarize;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		#1;
		`CHK("counter reset", 8'h00, tv)
		`CHK("direction reset", 6'h3F, dir)
		`CHK("option high bits reset", 2'h3, {wkd, pud})
		xfer(1'b0, `TMZ_IDX_TIMER, 8'h5A, a);
		xfer(1'b1, `TMZ_IDX_TIMER, 8'h00, a);
		`CHK("counter readback", 8'h5A, a)
		for (i = 0; i < 8; i = i + 1) begin
			xfer(1'b1, i[2:0], 8'h00, a);
			if (i != 1)
				`CHK("hidden read", 8'h00, a)
		end
		xfer(1'b0, `TMZ_IDX_DIRECTION, 8'h00, a);
		`CHK("pin forced input", 6'h04, dir)
		xfer(1'b0, `TMZ_IDX_OPTION, 8'h08, a);
		`CHK("pin released", 6'h00, dir)
		`CHK("option high bits written", 2'h0, {wkd, pud})
		// Bare timer: load, two blocked cycles, then one step per cycle
		xfer(1'b0, `TMZ_IDX_TIMER, 8'hF0, a);
		repeat (40) @(posedge mclk);
		#1;
		`CHK("counter after load", 8'hF8, tv)
		repeat (40) @(posedge mclk);
		#1;
		`CHK("counter rate", 8'h02, tv)
		`CHK("overflow pulses", 1, n_ovf)
		xfer(1'b0, `TMZ_IDX_WDCLEAR, 8'h00, a);
		`CHK("watchdog clear pulse", 1'b1, wdc)
		// Every ratio code: four prescaled periods give four steps
		for (i = 0; i < 8; i = i + 1) begin
			xfer(1'b0, `TMZ_IDX_OPTION, i[7:0], a);
			xfer(1'b0, `TMZ_IDX_TIMER, 8'h00, a);
			repeat (40) @(posedge mclk);
			#1;
			b = tv;
			repeat (32 << i) @(posedge mclk);
			#1;
			`CHK("prescaled steps", 8'h04, tv - b)
		end
		// A load must restart the slowest prescaler from zero
		xfer(1'b0, `TMZ_IDX_TIMER, 8'h00, a);
		repeat (510) @(posedge mclk);
		#1;
		`CHK("prescaler cleared by load", 8'h00, tv)
		xfer(1'b0, `TMZ_IDX_WDCLEAR, 8'h00, a);
		xfer(1'b0, `TMZ_IDX_TIMER, 8'h00, a);
		xfer(1'b0, `TMZ_IDX_OPTION, 8'h2F, a);
		xfer(1'b0, `TMZ_IDX_WDCLEAR, 8'h00, a);
		// Pin edges: rising, falling, then prescaled 1:2 and 1:4
		for (i = 0; i < 4; i = i + 1) begin
			b = (i == 0) ? 8'h28 : (i == 1) ? 8'h38 : (i == 2) ? 8'h20 : 8'h21;
			xfer(1'b0, `TMZ_IDX_WDCLEAR, 8'h00, a);
			xfer(1'b0, `TMZ_IDX_OPTION, b, a);
			xfer(1'b0, `TMZ_IDX_TIMER, 8'h00, a);
			repeat (12) @(posedge mclk);
			start <= 1'b1;
			@(posedge mclk);
			start <= 1'b0;
			repeat (80) @(posedge mclk);
			#1;
			`CHK("external edges", (i < 2) ? 8'h08 : 8'h08 >> (i - 1), tv)
		end
		summarize;
	end
endmodule // tb
